/* include/pgio_defines.svh */
/*
 * Register indices, field positions, masks, zero constants and pin roles for the
 * programmable io port. Included by the package and the port logic.
 */
`ifndef PGIO_DEFINES_SVH
`define PGIO_DEFINES_SVH

`define PGIO_IDX_DIR      2'h0
`define PGIO_IDX_LEVEL    2'h1
`define PGIO_IDX_IEN      2'h2
`define PGIO_IDX_CTRL     2'h3

`define PGIO_CTRL_LATCH   0
`define PGIO_CTRL_MODEM   1
`define PGIO_CTRL_SOFT_RESET_BIT  3

`define PGIO_PIN_DSR      4
`define PGIO_PIN_DTR      5
`define PGIO_PIN_CD       6
`define PGIO_PIN_RI       7

`define PGIO_MASK_ALL     8'hFF
`define PGIO_MASK_LOW     8'h0F
`define PGIO_BYTE_ZERO    8'h00
`define PGIO_MDM_ZERO     3'h0

`endif

/* include/pgio_pkg.sv */
/*
 * Types shared by the programmable io port and its surroundings.
 * Assumes the defines header is on the include path.
 */
`include "pgio_defines.svh"

package pgio_pkg;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] idx;
		logic [7:0] wdata;
	} pgio_req_s;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pgio_drive_s;

	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] lvl_out;
		logic [7:0] ien;
		logic       latch;
		logic       modem;
		logic       soft_reset_bit;
		logic [7:0] ref_lvl;
		logic [7:0] pend;
		logic [7:0] cap;
		logic [2:0] mdm_prev;
		logic [7:0] rdata;
		pgio_drive_s drive;
		logic       mdm_evt;
		logic       srst_pulse;
	} pgio_state_s;

endpackage : pgio_pkg

/* rtl/pgio_port.sv */
/*
 * Eight-pin programmable io port with change interrupts, input latching,
 * modem pin sharing of the upper nibble and self-clearing soft reset.
 * Assumes a register port synchronous to i_clk_sys; pins sampled
 * synchronously; modem interrupt enable and terminal-ready come from the uart.
 */
`timescale 1ns/1ns
`include "pgio_defines.svh"

module pgio_port (
	input  wire logic                i_clk_sys,
	input  wire logic                i_rst_n,
	input  wire pgio_pkg::pgio_req_s i_req,
	output logic [7:0]               o_rdata,
	input  wire logic [7:0]          i_pin_in,
	output pgio_pkg::pgio_drive_s    o_drive,
	input  wire logic                i_modem_irq_enable,
	input  wire logic                i_modem_dtr,
	output logic [2:0]               o_modem_lines,
	output logic                     o_modem_change,
	output logic                     o_irq,
	output logic                     o_soft_reset
);
	import pgio_pkg::*;

	pgio_state_s s_reg;
	pgio_state_s s_next;
	logic [7:0]  gpio_mask;
	logic [7:0]  arm;
	logic [7:0]  chg;
	logic [7:0]  fresh;
	logic [2:0]  lines;
	logic [7:0]  nmask;

	assign lines = {i_pin_in[`PGIO_PIN_RI], i_pin_in[`PGIO_PIN_CD],
		i_pin_in[`PGIO_PIN_DSR]};

	always_comb begin
		s_next = s_reg;
		s_next.mdm_evt = 1'b0;
		s_next.srst_pulse = 1'b0;
		gpio_mask = s_reg.modem ? `PGIO_MASK_LOW : `PGIO_MASK_ALL;
		arm = ~s_reg.dir & gpio_mask & s_reg.ien;
		chg = i_pin_in ^ s_reg.ref_lvl;
		fresh = chg & arm & ~s_reg.pend;
		// unarmed pins keep tracking so enabling later starts clean
		s_next.ref_lvl = (s_reg.ref_lvl & arm) | (i_pin_in & ~arm);
		if (s_reg.latch) begin
			s_next.pend = (s_reg.pend & arm) | fresh;
			s_next.cap = (s_reg.cap & ~fresh) | (i_pin_in & fresh);
		end else begin
			s_next.pend = chg & arm;
		end
		s_next.mdm_prev = lines;
		s_next.mdm_evt = s_reg.modem & i_modem_irq_enable
			& (lines != s_reg.mdm_prev);
		if (i_req.rd) begin
			unique case (i_req.idx)
				`PGIO_IDX_DIR:   s_next.rdata = s_reg.dir;
				`PGIO_IDX_LEVEL: s_next.rdata = s_reg.latch
					? ((s_reg.cap & s_reg.pend) | (i_pin_in & ~s_reg.pend))
					: i_pin_in;
				`PGIO_IDX_IEN:   s_next.rdata = s_reg.ien;
				`PGIO_IDX_CTRL:  s_next.rdata = {4'h0, s_reg.soft_reset_bit, 1'b0,
					s_reg.modem, s_reg.latch};
			endcase
			if (i_req.idx == `PGIO_IDX_LEVEL) begin
				s_next.ref_lvl = i_pin_in;
				s_next.pend = s_reg.latch ? fresh : `PGIO_BYTE_ZERO;
			end
		end
		if (i_req.wr) begin
			unique case (i_req.idx)
				`PGIO_IDX_DIR: begin
					s_next.dir = i_req.wdata;
					s_next.pend = `PGIO_BYTE_ZERO;
					s_next.ref_lvl = i_pin_in;
				end
				`PGIO_IDX_LEVEL: s_next.lvl_out = i_req.wdata;
				`PGIO_IDX_IEN:   s_next.ien = i_req.wdata;
				`PGIO_IDX_CTRL: begin
					s_next.latch = i_req.wdata[`PGIO_CTRL_LATCH];
					s_next.modem = i_req.wdata[`PGIO_CTRL_MODEM];
					s_next.soft_reset_bit = i_req.wdata[`PGIO_CTRL_SOFT_RESET_BIT];
				end
			endcase
		end
		if (s_reg.soft_reset_bit) begin
			s_next = '0;
			s_next.srst_pulse = 1'b1;
		end
		nmask = s_next.modem ? `PGIO_MASK_LOW : `PGIO_MASK_ALL;
		s_next.drive.oe = s_next.dir & nmask;
		s_next.drive.out = s_next.lvl_out & s_next.dir & nmask;
		if (s_next.modem) begin
			s_next.drive.oe[`PGIO_PIN_DTR] = 1'b1;
			s_next.drive.out[`PGIO_PIN_DTR] = ~i_modem_dtr;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_rdata = s_reg.rdata;
	assign o_drive = s_reg.drive;
	assign o_modem_lines = s_reg.modem ? s_reg.mdm_prev : `PGIO_MDM_ZERO;
	assign o_modem_change = s_reg.mdm_evt;
	assign o_irq = |s_reg.pend;
	assign o_soft_reset = s_reg.srst_pulse;

	a_dir_clears_irq: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		i_req.wr && i_req.idx == `PGIO_IDX_DIR && !s_reg.soft_reset_bit |=> !o_irq)
		else $error("direction write did not clear interrupt");

	a_level_read_val: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		i_req.rd && i_req.idx == `PGIO_IDX_LEVEL && !s_reg.latch
		&& !s_reg.soft_reset_bit |=> o_rdata == $past(i_pin_in))
		else $error("level read did not return pin states");

	a_out_drive: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		i_req.wr && i_req.idx == `PGIO_IDX_LEVEL && !s_reg.soft_reset_bit
		&& !s_reg.modem
		|=> o_drive.out == ($past(i_req.wdata) & s_reg.dir))
		else $error("output pins not driven to written value");

	a_enable_gate: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		s_reg.ien == `PGIO_BYTE_ZERO && !o_irq && !i_req.wr |=> !o_irq)
		else $error("interrupt raised with all enables clear");

	a_soft_reset_bit_clear: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		s_reg.soft_reset_bit |=> !s_reg.soft_reset_bit && o_soft_reset
		&& o_drive.oe == `PGIO_BYTE_ZERO)
		else $error("soft reset did not act and self-clear");

	a_unlatch_revert: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		!s_reg.latch && !i_req.wr && !s_reg.soft_reset_bit
		&& i_pin_in == s_reg.ref_lvl |=> !o_irq)
		else $error("unlatched interrupt not withdrawn on revert");

	a_latch_hold: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		s_reg.latch && o_irq && !i_req.wr && !i_req.rd && !s_reg.soft_reset_bit
		&& $stable(s_reg.dir) ##0 $stable(s_reg.ien) |=> o_irq)
		else $error("latched interrupt lost before read");

	a_io_no_modem: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		!s_reg.modem |-> o_modem_lines == `PGIO_MDM_ZERO && !o_modem_change)
		else $error("modem status reported in io mode");

	a_oe_follow_dir: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		!s_reg.modem
		|-> o_drive.oe == s_reg.dir)
		else $error("pin enables do not follow direction");

	a_out_only_driven: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		1'b1
		|-> (o_drive.out & ~o_drive.oe) == `PGIO_BYTE_ZERO)
		else $error("undriven pin shows a high output value");

	a_modem_upper_off: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		s_reg.modem |-> !o_drive.oe[`PGIO_PIN_RI]
		&& !o_drive.oe[`PGIO_PIN_CD] && !o_drive.oe[`PGIO_PIN_DSR])
		else $error("modem input pin driven by io registers");

	a_dtr_follow: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		s_next.modem |=> o_drive.oe[`PGIO_PIN_DTR]
		&& o_drive.out[`PGIO_PIN_DTR] == !$past(i_modem_dtr))
		else $error("terminal ready pin not following uart");

	a_io_no_dtr: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		!s_reg.modem |-> o_drive.out[`PGIO_PIN_DTR]
		== (s_reg.lvl_out[`PGIO_PIN_DTR] & s_reg.dir[`PGIO_PIN_DTR]))
		else $error("terminal ready driven by uart in io mode");

	a_rise_needs_en: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		$rose(o_irq)
		|-> $past(s_reg.ien) != `PGIO_BYTE_ZERO)
		else $error("interrupt raised with no pin enabled");

	a_unlatch_rdclr: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		i_req.rd && i_req.idx == `PGIO_IDX_LEVEL && !s_reg.latch
		&& !i_req.wr |=> !o_irq)
		else $error("unlatched interrupt not cleared by level read");

	a_modem_event: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		s_reg.modem && i_modem_irq_enable && !s_reg.soft_reset_bit
		&& lines != s_reg.mdm_prev |=> o_modem_change)
		else $error("modem line change not reported");

	a_ctrl_read: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n)
		i_req.rd && i_req.idx == `PGIO_IDX_CTRL && !i_req.wr
		&& !s_reg.soft_reset_bit |=> o_rdata[`PGIO_CTRL_MODEM] == s_reg.modem)
		else $error("control read does not show pin function");

endmodule : pgio_port

/* dv/pgio_host.sv */
/* host model: issues register requests to the io port.
   assumes a clock shared with the port. */
`timescale 1ns/1ns
module pgio_host (
	input  wire logic          i_clk_sys,
	output pgio_pkg::pgio_req_s o_req
);
	import pgio_pkg::*;
	initial o_req = '0;
	// one-cycle strobe; a gap cycle follows
	task automatic xfer(input logic w, input logic [1:0] idx,
		input logic [7:0] d);
		@(posedge i_clk_sys);
		o_req <= {w, ~w, idx, d};
		@(posedge i_clk_sys);
		o_req <= '0;
	endtask : xfer
endmodule : pgio_host

/* dv/tb_programmable_io_port.sv */
/* self-checking bench for the io port.
   assumes the host model and the package are compiled first. */
`timescale 1ns/1ns
module tb_programmable_io_port;
	import pgio_pkg::*;
	logic        clk = 1'h0, rst_n = 1'h0, men = 1'h0, dtr = 1'h0;
	logic [7:0]  pins = 8'h00, rdata, lf = 8'h43, p;
	logic [2:0]  mlines;
	logic        mchg, irq, srst;
	pgio_req_s   req;
	pgio_drive_s drv;
	int          err_count = 0, samples_checked = 0;
	always #20 clk = ~clk;
	pgio_host host_u (.i_clk_sys(clk), .o_req(req));
	pgio_port dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_req(req),
		.o_rdata(rdata), .i_pin_in(pins), .o_drive(drv),
		.i_modem_irq_enable(men), .i_modem_dtr(dtr),
		.o_modem_lines(mlines), .o_modem_change(mchg), .o_irq(irq),
		.o_soft_reset(srst));
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : nxt
	task automatic chk(input string n, input logic [7:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic irqc(input logic e);
		chk("irq", 8'(e), 8'(irq));
	endtask : irqc
	task automatic rd(input logic [1:0] i);
		host_u.xfer(1'h0, i, 8'h00);
		@(negedge clk);
	endtask : rd
	task automatic pin(input logic [7:0] v);
		@(posedge clk);
		pins <= v;
		repeat (3) @(negedge clk);
	endtask : pin
	task automatic conclude;
		if (err_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		host_u.xfer(1'h1, 2'h0, 8'h0F);
		lf = nxt(lf);
		host_u.xfer(1'h1, 2'h1, lf);
		rd(2'h1);
		chk("drive_out", lf & 8'h0F, drv.out);
		chk("drive_oe", 8'h0F, drv.oe);
		lf = nxt(lf);
		pin(lf);
		rd(2'h1);
		chk("level", lf, rdata);
		host_u.xfer(1'h1, 2'h0, 8'h00);
		host_u.xfer(1'h1, 2'h2, 8'h01);
		pin(lf ^ 8'h02);
		irqc(1'h0);
		pin(lf ^ 8'h03);
		irqc(1'h1);
		pin(lf ^ 8'h02);
		irqc(1'h0);
		p = lf ^ 8'h03;
		pin(p);
		rd(2'h1);
		irqc(1'h0);
		host_u.xfer(1'h1, 2'h3, 8'h01);
		pin(p ^ 8'h01);
		pin(p);
		irqc(1'h1);
		rd(2'h1);
		chk("latched", p ^ 8'h01, rdata);
		irqc(1'h0);
		pin(p ^ 8'h01);
		host_u.xfer(1'h1, 2'h0, 8'h00);
		@(negedge clk);
		irqc(1'h0);
		@(posedge clk);
		dtr <= 1'h1;
		host_u.xfer(1'h1, 2'h3, 8'h02);
		host_u.xfer(1'h1, 2'h0, 8'hF0);
		host_u.xfer(1'h1, 2'h2, 8'hFF);
		pin(pins ^ 8'h80);
		chk("modem_oe", 8'h20, drv.oe);
		chk("modem_out", 8'h00, drv.out);
		irqc(1'h0);
		@(posedge clk);
		men <= 1'h1;
		pins <= pins ^ 8'h40;
		@(negedge clk);
		chk("modem_chg_early", 8'h00, 8'(mchg));
		@(negedge clk);
		chk("modem_chg", 8'h01, 8'(mchg));
		chk("modem_lines", 8'({pins[7], pins[6], pins[4]}), 8'(mlines));
		irqc(1'h0);
		host_u.xfer(1'h1, 2'h3, 8'h08);
		for (int k = 0; k < 4 && srst !== 1'h1; k++) @(negedge clk);
		chk("soft_reset", 8'h01, 8'(srst));
		rd(2'h3);
		chk("control", 8'h00, rdata);
		rd(2'h0);
		chk("direction", 8'h00, rdata);
		chk("io_lines", 8'h00, 8'(mlines));
		@(posedge clk);
		pins <= pins ^ 8'h10;
		repeat (2) @(negedge clk);
		chk("io_chg", 8'h00, 8'(mchg));
		conclude();
	end
	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		conclude();
	end
endmodule : tb_programmable_io_port
